// ---- pkg/scs_pkg.sv ----
// constants and types for the system clock source switch
package scs_pkg;
   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [7:0] OFS_OSC  = 8'h00; // osc_control_reg
   localparam logic [7:0] OFS_OSC2 = 8'h04; // osc_control_second_reg
   localparam logic [7:0] OFS_CFG  = 8'h08; // config_word_high image
   localparam logic [7:0] OFS_STAT = 8'h0C; // switch state, read only
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int B_IDLE  = 7; // idle_on_sleep_select
   localparam int B_FRQ   = 4; // internal_freq_field, 3 bits
   localparam int B_PRI   = 3; // primary active flag
   localparam int B_FAST  = 2; // fast_internal_stable_flag
   localparam int B_CS    = 0; // clock_select_field, 2 bits
   localparam int B_SRUN  = 6; // secondary_running_flag
   localparam int B_MSEL  = 4; // medium_source_select
   localparam int B_FORCE = 3; // secondary_force_on
   localparam int B_MED   = 1; // medium_internal_stable_flag
   localparam int B_ISRC  = 0; // internal_source_select
   localparam int B_IPRI  = 1; // internal block is the primary
   localparam int B_PLL   = 2; // crystal_pll_mode
   localparam int B_WDT   = 3; // watchdog_timer enabled
   localparam int B_FAIL_SAFE_CLOCK_MONITOR  = 4; // fail_safe_clock_monitor on
   // ----------------------------------------
   // sources and responses
   // ----------------------------------------
   localparam logic [1:0] SRC_PRI  = 2'h0;
   localparam logic [1:0] SRC_SEC  = 2'h1;
   localparam logic [1:0] SRC_INT  = 2'h2;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ      = 50;
   localparam int OST_TICKS    = 1024;    // primary start-up periods
   localparam int PLL_LOCK_NS  = 2000000; // pll_lock_time, 2 ms
   localparam int PLL_LOCK_CYC = PLL_LOCK_NS / 1000 * CLK_MHZ;
   localparam int STAB_NS      = 1000;    // internal_stabilise_time
   localparam int STAB_CYC     = (STAB_NS * CLK_MHZ + 999) / 1000;
   localparam logic [1:0] OLD_EDGES = 2'h2; // outgoing clock edges
   localparam logic [1:0] NEW_EDGES = 2'h3; // incoming clock edges
   // ----------------------------------------
   // state types
   // ----------------------------------------
   typedef enum logic [3:0] {
      SW_RUN  = 4'h1, // stable on sel
      SW_WAIT = 4'h2, // old clock runs, new warming up
      SW_OLD  = 4'h4, // releasing old clock
      SW_NEW  = 4'h8  // picking up new clock
   } scs_sw_t;
   typedef enum logic [2:0] {
      PW_RUN   = 3'h1,
      PW_IDLE  = 3'h2,
      PW_SLEEP = 3'h4
   } scs_pwr_t;
endpackage

// ---- design/scs_clock_switch.sv ----
// system clock source switch with AXI4-Lite control registers
//
// Summary of operation
// - switch takes 2 old, 3 new edges
// - four status bits at fixed positions
// - flags encode which source drives clock
// - internal-as-primary may show both flags
// - sleep samples idle select when executed
// - every run mode clocks core and peripherals
// - reset starts primary run, primary flag set
// - select 01 moves to secondary oscillator
// - force-on bit makes secondary switch immediate
// - secondary clocks until primary ready
// - upper select bit picks internal, lower ignored
// - frequency field writes act at once
// - field zero, source clear: low-frequency, no flags
// - decode field and selects into stable flags
// - stable flag only after output settles
// - already stable source keeps flag set
// - internal clocks until primary ready
// - low-frequency source kept for watchdog/monitor
// - primary ready after 1024 periods plus pll
// - select field 00/01/1x maps to sources
// - sleep stops all clocks, idle only cpu
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_switch
   import scs_pkg::*;
#(
   parameter int PLL_CYC = PLL_LOCK_CYC // pll lock wait in aclk cycles
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        primary_tick,
   input  wire logic        secondary_tick,
   input  wire logic        internal_tick,
   input  wire logic        lf_tick,
   input  wire logic        secondary_stable,
   input  wire logic        sleep_exec,
   input  wire logic        wake_event,
   output logic             sys_tick,
   output logic             cpu_tick,
   output logic             periph_tick,
   output logic [2:0]       internal_freq,
   output logic             primary_osc_en,
   output logic             secondary_osc_en,
   output logic             internal_osc_en,
   output logic             lf_osc_en
);
   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic [7:0]  osc_q;       // writable osc control bits
   logic [7:0]  osc2_q;      // writable second control bits
   logic [7:0]  cfg_q;       // configuration image
   scs_sw_t     sw_q;        // switch sequencer
   scs_pwr_t    pwr_q;       // run / idle / sleep
   logic [1:0]  sel_q;       // source now driving
   logic [1:0]  nxt_q;       // source being switched to
   logic [1:0]  ecnt_q;      // clock edges counted
   logic [10:0] ost_q;       // primary start-up count
   logic [16:0] pll_q;       // pll lock count
   logic [7:0]  stab_q;      // internal settle count
   logic        aw_q;        // write address held
   logic        w_q;         // write data held
   logic [7:0]  awa_q;       // held write address
   logic [7:0]  wd_q;        // held write byte
   logic        wen_q;       // held byte lane 0 enable
   logic [3:0]  sy1, sy2, sy3; // tick synchronisers
   logic [3:0]  edge_w;      // one pulse per source edge
   logic [1:0]  tgt;         // target from select field
   logic        int_en;      // internal output enabled
   logic        int_stab;    // internal output settled
   logic        pri_rdy;     // primary clock usable
   logic [3:0]  rdy;         // per-source ready, top entry unused
   logic [3:0]  stk;         // per-source tick, top entry unused
   logic        asleep;      // all clocks stopped
   logic        pri_flag, sec_flag, fast_flag, med_flag;
   logic        int_show;    // internal flags visible
   logic        wr_go;       // register write this cycle
   logic        run_ok;      // mux settled, selected edge seen

   // ----------------------------------------
   // source tick synchronisers
   // ----------------------------------------
   wire [3:0] raw = {lf_tick, internal_tick, secondary_tick, primary_tick};
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         // two flops, third only for the edge
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sy1[g] <= 1'b0;
               sy2[g] <= 1'b0;
               sy3[g] <= 1'b0;
            end else begin
               sy1[g] <= raw[g];
               sy2[g] <= sy1[g];
               sy3[g] <= sy2[g];
            end
         end
         assign edge_w[g] = sy2[g] & ~sy3[g];
      end
   endgenerate

   // ----------------------------------------
   // source decode
   // ----------------------------------------
   // upper bit wins, lower ignored then
   assign tgt = osc_q[B_CS+1] ? SRC_INT : {1'b0, osc_q[B_CS]};
   // output on for nonzero field or either select
   assign int_en = (osc_q[B_FRQ+:3] != 3'h0) | cfg_q[B_ISRC] | osc2_q[B_MSEL];
   assign int_stab = (stab_q == 8'(STAB_CYC));
   assign asleep = (pwr_q == PW_SLEEP);
   // ready figures per source
   assign rdy[SRC_PRI] = pri_rdy;
   assign rdy[SRC_SEC] = osc2_q[B_FORCE] | secondary_stable;
   assign rdy[SRC_INT] = ~int_en | int_stab;
   assign rdy[3]      = 1'b0;
   // low-frequency source stands in when output is off
   assign stk[SRC_PRI] = edge_w[0];
   assign stk[SRC_SEC] = edge_w[1];
   assign stk[SRC_INT] = int_en ? edge_w[2] : edge_w[3];
   assign stk[3]      = 1'b0;
   // frequency field goes straight out
   assign internal_freq = osc_q[B_FRQ+:3];

   // ----------------------------------------
   // oscillator enables
   // ----------------------------------------
   always_comb begin
      primary_osc_en   = ~asleep & (sel_q == SRC_PRI | tgt == SRC_PRI);
      secondary_osc_en = osc2_q[B_FORCE] | (~asleep & (sel_q == SRC_SEC | tgt == SRC_SEC));
      internal_osc_en  = ~asleep & int_en;
      // kept for watchdog or monitor
      lf_osc_en = cfg_q[B_WDT] | cfg_q[B_FAIL_SAFE_CLOCK_MONITOR] | (~asleep & ~int_en);
   end

   // ----------------------------------------
   // primary readiness
   // ----------------------------------------
   // counts primary periods, then pll lock time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ost_q <= 11'(OST_TICKS);
         pll_q <= 17'h0;
      end else if (!primary_osc_en) begin
         ost_q <= 11'h0;
         pll_q <= 17'h0;
      end else if (ost_q != 11'(OST_TICKS)) begin
         if (edge_w[0])
            ost_q <= ost_q + 11'h1;
      end else if (cfg_q[B_PLL] && pll_q != 17'(PLL_CYC)) begin
         pll_q <= pll_q + 17'h1;
      end
   end
   assign pri_rdy = (ost_q == 11'(OST_TICKS)) & (~cfg_q[B_PLL] | pll_q == 17'(PLL_CYC));

   // ----------------------------------------
   // internal stabilisation
   // ----------------------------------------
   // restarts when the output is turned off or in sleep
   always_ff @(posedge aclk) begin
      if (!aresetn)
         stab_q <= 8'h0;
      else if (!int_en || asleep)
         stab_q <= 8'h0;
      else if (!int_stab)
         stab_q <= stab_q + 8'h1;
   end

   // ----------------------------------------
   // switch sequencer
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_q   <= SW_RUN;
         sel_q  <= SRC_PRI;
         nxt_q  <= SRC_PRI;
         ecnt_q <= 2'h0;
      end else begin
         case (sw_q)
            SW_RUN: begin
               // new request, wait unless already ready
               if (tgt != sel_q && !asleep) begin
                  nxt_q  <= tgt;
                  ecnt_q <= 2'h0;
                  sw_q   <= rdy[tgt] ? SW_OLD : SW_WAIT;
               end
            end
            SW_WAIT: begin
               // old source keeps clocking meanwhile
               if (tgt == sel_q)
                  sw_q <= SW_RUN;
               else if (tgt != nxt_q)
                  nxt_q <= tgt;
               else if (rdy[nxt_q])
                  sw_q <= SW_OLD;
            end
            SW_OLD: begin
               // release old clock on its own edges
               if (stk[sel_q]) begin
                  if (ecnt_q == OLD_EDGES - 2'h1) begin
                     ecnt_q <= 2'h0;
                     sw_q   <= SW_NEW;
                  end else
                     ecnt_q <= ecnt_q + 2'h1;
               end
            end
            SW_NEW: begin
               // pick up new clock on its own edges
               if (stk[nxt_q]) begin
                  if (ecnt_q == NEW_EDGES - 2'h1) begin
                     ecnt_q <= 2'h0;
                     sel_q  <= nxt_q;
                     sw_q   <= SW_RUN;
                  end else
                     ecnt_q <= ecnt_q + 2'h1;
               end
            end
            default: sw_q <= SW_RUN;
         endcase
      end
   end

   // ----------------------------------------
   // power mode
   // ----------------------------------------
   // sleep decides by the idle bit at that moment
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pwr_q <= PW_RUN;
      else begin
         case (pwr_q)
            PW_RUN: begin
               if (sleep_exec)
                  pwr_q <= osc_q[B_IDLE] ? PW_IDLE : PW_SLEEP;
            end
            PW_IDLE, PW_SLEEP: begin
               if (wake_event)
                  pwr_q <= PW_RUN;
            end
            default: pwr_q <= PW_RUN;
         endcase
      end
   end

   // ----------------------------------------
   // clock ticks out
   // ----------------------------------------
   // internal output keeps clocking while it settles
   assign run_ok = (sw_q == SW_RUN || sw_q == SW_WAIT) && stk[sel_q] &&
                   (rdy[sel_q] || sel_q == SRC_INT);
   // no ticks while the mux changes hands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_tick    <= 1'b0;
         cpu_tick    <= 1'b0;
         periph_tick <= 1'b0;
      end else begin
         sys_tick    <= run_ok && !asleep;
         cpu_tick    <= run_ok && pwr_q == PW_RUN;
         periph_tick <= run_ok && !asleep;
      end
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   always_comb begin
      pri_flag  = ~asleep & sel_q == SRC_PRI & pri_rdy;
      sec_flag  = ~asleep & sel_q == SRC_SEC;
      // internal flags, also with internal as primary
      int_show  = ~asleep & int_en & int_stab &
                  (sel_q == SRC_INT | (sel_q == SRC_PRI & cfg_q[B_IPRI]));
      fast_flag = int_show & ~osc2_q[B_MSEL];
      med_flag  = int_show & osc2_q[B_MSEL];
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign awready = ~aw_q & ~bvalid;
   assign wready  = ~w_q & ~bvalid;
   assign wr_go   = aw_q & w_q;
   // address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         awa_q <= 8'h0;
         wd_q  <= 8'h0;
         wen_q <= 1'b0;
         bvalid <= 1'b0;
         bresp  <= RESP_OK;
      end else begin
         if (awvalid && awready) begin
            aw_q  <= 1'b1;
            awa_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_q   <= 1'b1;
            wd_q  <= wdata[7:0];
            wen_q <= wstrb[0];
         end
         if (wr_go) begin
            aw_q   <= 1'b0;
            w_q    <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= (awa_q == OFS_OSC || awa_q == OFS_OSC2 || awa_q == OFS_CFG ||
                       awa_q == OFS_STAT) ? RESP_OK : RESP_ERR;
         end else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // register updates, status bits read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_q  <= 8'h00;
         osc2_q <= 8'h00;
         cfg_q  <= 8'h00;
      end else if (wr_go && wen_q) begin
         case (awa_q)
            OFS_OSC:  osc_q  <= wd_q & 8'hF3;
            OFS_OSC2: osc2_q <= wd_q & 8'h18;
            OFS_CFG:  cfg_q  <= wd_q & 8'h1F;
            default:  ;
         endcase
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   assign arready = ~rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= RESP_OK;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp  <= RESP_OK;
         case (araddr)
            OFS_OSC:  rdata <= {24'h0, osc_q | (8'(pri_flag) << B_PRI) | (8'(fast_flag) << B_FAST)};
            OFS_OSC2: rdata <= {24'h0, osc2_q | (8'(sec_flag) << B_SRUN) | (8'(med_flag) << B_MED)};
            OFS_CFG:  rdata <= {24'h0, cfg_q};
            OFS_STAT: rdata <= {21'h0, nxt_q, sel_q, pwr_q, sw_q};
            default: begin
               rdata <= 32'h0;
               rresp <= RESP_ERR;
            end
         endcase
      end else if (rvalid && rready)
         rvalid <= 1'b0;
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_old_done;
      sw_q == SW_OLD && stk[sel_q] && ecnt_q == OLD_EDGES - 2'h1;
   endsequence
   sequence s_new_done;
      sw_q == SW_NEW && stk[nxt_q] && ecnt_q == NEW_EDGES - 2'h1;
   endsequence
   property p_old_edges;
      @(posedge aclk) disable iff (!aresetn) s_old_done |=> sw_q == SW_NEW && ecnt_q == 2'h0;
   endproperty
   a_old_edges: assert property (p_old_edges) else $error("old clock release miscounted");
   property p_new_edges;
      @(posedge aclk) disable iff (!aresetn) s_new_done |=> sw_q == SW_RUN && sel_q == $past(nxt_q);
   endproperty
   a_new_edges: assert property (p_new_edges) else $error("new clock pickup miscounted");
   property p_reset_pri;
      @(posedge aclk) aresetn && !$past(aresetn) |-> sel_q == SRC_PRI && sw_q == SW_RUN;
   endproperty
   a_reset_pri: assert property (p_reset_pri) else $error("reset did not start primary");
   property p_sec_flags;
      @(posedge aclk) disable iff (!aresetn) sec_flag |-> !pri_flag && !fast_flag && !med_flag;
   endproperty
   a_sec_flags: assert property (p_sec_flags) else $error("secondary flag not alone");
   property p_idle_pick;
      @(posedge aclk) disable iff (!aresetn)
         pwr_q == PW_RUN && sleep_exec |=> pwr_q == ($past(osc_q[B_IDLE]) ? PW_IDLE : PW_SLEEP);
   endproperty
   a_idle_pick: assert property (p_idle_pick) else $error("sleep used wrong idle select");
   property p_sleep_quiet;
      @(posedge aclk) disable iff (!aresetn) (pwr_q == PW_SLEEP)[*2] |-> !periph_tick && !cpu_tick;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("clock ran in sleep");
   property p_wait_hold;
      @(posedge aclk) disable iff (!aresetn) sw_q == SW_WAIT ##1 sw_q == SW_WAIT |-> $stable(sel_q);
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("source moved before ready");
   property p_int_off;
      @(posedge aclk) disable iff (!aresetn) !int_en |-> !fast_flag && !med_flag;
   endproperty
   a_int_off: assert property (p_int_off) else $error("stable flag with output off");
   property p_no_tick_switch;
      @(posedge aclk) disable iff (!aresetn) sw_q == SW_OLD ##1 sw_q != SW_RUN |-> !sys_tick;
   endproperty
   a_no_tick_switch: assert property (p_no_tick_switch) else $error("tick during switch");
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the system clock source switch
`timescale 1ns/1ps
`default_nettype none
module tb
   import scs_pkg::*;
;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        aclk, aresetn;                                    // clock and sync reset
   logic [7:0]  awaddr, araddr;                                   // bus addresses
   logic        awvalid, awready, wvalid, wready, bvalid, bready; // write channels
   logic        arvalid, arready, rvalid, rready;                 // read channels
   logic [31:0] wdata, rdata, rd_q;                               // data, last read word
   logic [3:0]  wstrb;                                            // byte strobes
   logic [1:0]  bresp, rresp, resp_q;                             // responses, last response
   logic        primary_tick, secondary_tick, internal_tick, lf_tick;
   logic        secondary_stable, sleep_exec, wake_event;
   logic        sys_tick, cpu_tick, periph_tick;
   logic        primary_osc_en, secondary_osc_en, internal_osc_en, lf_osc_en;
   logic [2:0]  internal_freq;
   logic [4:0]  osc_cnt_q;                                        // divider for the source waves
   int          fail_count, samples_checked, n_cpu, n_per;
   // ----------------------------------------
   // clock, sources and design
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // source waves, all slower than a third of aclk
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_cnt_q <= 5'h00;
         {primary_tick, secondary_tick, internal_tick, lf_tick} <= 4'h0;
      end else begin
         osc_cnt_q      <= osc_cnt_q + 5'h01;
         primary_tick   <= osc_cnt_q[2];
         secondary_tick <= osc_cnt_q[3];
         internal_tick  <= osc_cnt_q[1];
         lf_tick        <= osc_cnt_q[4];
      end
   end
   scs_clock_switch #(.PLL_CYC(20)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .primary_tick(primary_tick),
      .secondary_tick(secondary_tick), .internal_tick(internal_tick), .lf_tick(lf_tick),
      .secondary_stable(secondary_stable), .sleep_exec(sleep_exec), .wake_event(wake_event),
      .sys_tick(sys_tick), .cpu_tick(cpu_tick), .periph_tick(periph_tick), .internal_freq(internal_freq),
      .primary_osc_en(primary_osc_en), .secondary_osc_en(secondary_osc_en),
      .internal_osc_en(internal_osc_en), .lf_osc_en(lf_osc_en)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // verdict and end of run
   task automatic final_report;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // bus write, ready sampled at negedge, acted on at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic ta, tw, dn;
      n = 0;
      dn = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!dn && n < 100) begin
         @(negedge aclk);
         n++;
         ta = awvalid & awready;
         tw = wvalid & wready;
         dn = bvalid;
         resp_q = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      chk(dn, 1'b1);
   endtask
   // bus read into rd_q and resp_q
   task automatic rd(input logic [7:0] a);
      int   n;
      logic ta, dn;
      n = 0;
      dn = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!dn && n < 100) begin
         @(negedge aclk);
         n++;
         ta = arvalid & arready;
         dn = rvalid;
         rd_q = rdata;
         resp_q = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      chk(dn, 1'b1);
   endtask
   // poll status until the given source runs settled
   task automatic wait_src(input logic [1:0] s);
      int n;
      n = 0;
      rd(OFS_STAT);
      while ((rd_q[8:7] !== s || rd_q[3:0] !== 4'h1) && n < 6000) begin
         rd(OFS_STAT);
         n++;
      end
      chk(rd_q[8:7], s);
   endtask
   // count core and peripheral ticks over a window
   task automatic ticks;
      n_cpu = 0;
      n_per = 0;
      repeat (48) begin
         @(negedge aclk);
         n_cpu += cpu_tick;
         n_per += periph_tick;
      end
      @(posedge aclk);
   endtask
   // one-cycle sleep or wake pulse
   task automatic pulse(input logic wake);
      if (wake) wake_event <= 1'b1;
      else sleep_exec <= 1'b1;
      @(posedge aclk);
      wake_event <= 1'b0;
      sleep_exec <= 1'b0;
      @(posedge aclk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd(OFS_OSC);
      chk(rd_q, 32'h0000_0008);
      rd(OFS_STAT);
      chk(rd_q, 32'h0000_0011);
      ticks;
      chk(n_cpu > 0 && n_per > 0, 1'b1);
      rd(8'h10);
      chk({rd_q[29:0], resp_q}, {30'h0, RESP_ERR});
      wr(8'h14, 32'h0000_00FF);
      chk(resp_q, RESP_ERR);
      wr(OFS_CFG, 32'h0000_0008);
      chk(resp_q, RESP_OK);
   endtask
   task automatic t_secondary;
      wr(OFS_OSC2, 32'h0000_0008);
      wr(OFS_OSC, 32'h0000_0001);
      wait_src(SRC_SEC);
      rd(OFS_OSC);
      chk(rd_q, 32'h0000_0001);
      rd(OFS_OSC2);
      chk(rd_q, 32'h0000_0048);
      chk(primary_osc_en, 1'b0);
   endtask
   task automatic t_to_primary;
      wr(OFS_OSC, 32'h0000_0000);
      rd(OFS_STAT);
      chk(rd_q[8:7], SRC_SEC);
      wait_src(SRC_PRI);
      rd(OFS_OSC);
      chk(rd_q, 32'h0000_0008);
      rd(OFS_OSC2);
      chk(rd_q, 32'h0000_0008);
      chk({secondary_osc_en, lf_osc_en}, 2'h3);
   endtask
   task automatic t_internal;
      wr(OFS_OSC, 32'h0000_0003);
      wait_src(SRC_INT);
      rd(OFS_OSC);
      chk(rd_q, 32'h0000_0003);
      chk(primary_osc_en, 1'b0);
      wr(OFS_OSC, 32'h0000_0033);
      chk(internal_freq, 3'h3);
      rd(OFS_OSC);
      chk(rd_q, 32'h0000_0033);
      ticks;
      chk(n_cpu > 8, 1'b1);
      chk({internal_osc_en, lf_osc_en}, 2'h3);
      repeat (STAB_CYC + 10) @(posedge aclk);
      rd(OFS_OSC);
      chk(rd_q, 32'h0000_0037);
      wr(OFS_OSC2, 32'h0000_0018);
      repeat (STAB_CYC + 10) @(posedge aclk);
      rd(OFS_OSC2);
      chk(rd_q, 32'h0000_001A);
   endtask
   task automatic t_sleep;
      wr(OFS_OSC, 32'h0000_00B3);
      pulse(1'b0);
      rd(OFS_STAT);
      chk(rd_q[6:4], 3'h2);
      ticks;
      chk({n_cpu == 0, n_per > 0}, 2'h3);
      pulse(1'b1);
      wr(OFS_OSC, 32'h0000_0033);
      pulse(1'b0);
      rd(OFS_STAT);
      chk(rd_q[6:4], 3'h4);
      rd(OFS_OSC2);
      chk(rd_q, 32'h0000_0018);
      ticks;
      chk(n_cpu + n_per, 0);
      chk({sys_tick, internal_osc_en}, 2'h0);
      pulse(1'b1);
      rd(OFS_STAT);
      chk(rd_q[6:4], 3'h1);
   endtask
   task automatic t_int_to_primary;
      wr(OFS_OSC, 32'h0000_0030);
      rd(OFS_STAT);
      chk(rd_q[8:7], SRC_INT);
      wait_src(SRC_PRI);
      rd(OFS_OSC);
      chk(rd_q, 32'h0000_0038);
      rd(OFS_OSC2);
      chk(rd_q, 32'h0000_0018);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      fail_count = 0;
      samples_checked = 0;
      aresetn = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, arvalid, sleep_exec, wake_event, secondary_stable} = '0;
      bready = 1'b1;
      rready = 1'b1;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_secondary;
      t_to_primary;
      t_internal;
      t_sleep;
      t_int_to_primary;
      final_report;
   end
   // two primary recounts dominate the run, about 20000 cycles
   initial begin
      #(60000 * 20);
      fail_count++;
      final_report;
   end
endmodule
`default_nettype wire
